/* hw/adc_ctrl_pkg.sv */
/*
 * Shared constants and types for the converter control block: command
 * codes, output codings, power states, wake timing and the register map
 * of the host end.
 * Assumes one 40 MHz clock shared by both ends.
 */
`default_nettype none

package adc_ctrl_pkg;

	// ********************************************************
	// Widths
	// ********************************************************
	localparam int SAMPLE_W   = 12;
	localparam int WORD_W     = 13;
	localparam int PIPE_DEPTH = 9;
	localparam int WAKE_W     = 9;

	// ********************************************************
	// Enumerations
	// ********************************************************
	typedef enum logic [1:0] {
		DIV_BY_1 = 2'b00,
		DIV_BY_2 = 2'b01,
		DIV_BY_4 = 2'b10
	} div_sel_t;

	typedef enum logic [1:0] {
		FMT_OFFSET = 2'b00,
		FMT_TWOS   = 2'b01,
		FMT_GRAY   = 2'b10
	} fmt_t;

	typedef enum logic [1:0] {
		PWR_RUN     = 2'b00,
		PWR_DOWN    = 2'b01,
		PWR_STANDBY = 2'b10
	} pwr_cmd_t;

	typedef enum logic [1:0] {
		PIN_NONE       = 2'b00,
		PIN_POWER_DOWN = 2'b01,
		PIN_OUT_ENABLE = 2'b10
	} pin_fn_t;

	typedef enum logic [1:0] {
		ST_RUN     = 2'b00,
		ST_STANDBY = 2'b01,
		ST_DOWN    = 2'b10,
		ST_WAKE    = 2'b11
	} pwr_state_t;

	// ********************************************************
	// Command addresses and strap levels
	// ********************************************************
	localparam logic [1:0] CMD_DIV     = 2'h0;
	localparam logic [1:0] CMD_POWER   = 2'h1;
	localparam logic [1:0] CMD_FORMAT  = 2'h2;
	localparam logic [1:0] CMD_PIN_FN  = 2'h3;
	localparam logic [1:0] CMD_ILLEGAL = 2'h3;
	localparam logic [1:0] SENSE_GND   = 2'h0;
	localparam logic [1:0] SENSE_ANALOG_SUPPLY  = 2'h3;

	// ********************************************************
	// Timing
	// ********************************************************
	localparam int CLK_PERIOD_NS   = 25;
	localparam int STANDBY_WAKE_NS = 1000;
	localparam int PD_WAKE_MAX_NS  = 10000;
	localparam logic [WAKE_W-1:0] STANDBY_WAKE_CYC = WAKE_W'(
		(STANDBY_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [WAKE_W-1:0] PD_WAKE_MAX_CYC = WAKE_W'(
		PD_WAKE_MAX_NS / CLK_PERIOD_NS);

	// ********************************************************
	// Host register map (byte addresses)
	// ********************************************************
	localparam logic [3:0]  ADR_CTRL    = 4'h0;
	localparam logic [3:0]  ADR_CMD     = 4'h4;
	localparam logic [3:0]  ADR_SAMPLE  = 4'h8;
	localparam int          CTRL_W      = 7;
	localparam int          CTRL_SERIAL = 0;
	localparam int          CTRL_POWER_DOWN_STRAP   = 1;
	localparam int          CTRL_FMT    = 2;
	localparam int          CTRL_DPD    = 3;
	localparam int          CTRL_MODE   = 4;
	localparam int          CTRL_SENSE  = 5;
	localparam int          CMD_ADR_LSB = 0;
	localparam int          CMD_DAT_LSB = 4;
	localparam int          SMP_OE_BIT  = 16;
	localparam int          SMP_CNT_LSB = 24;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h00;

endpackage

`default_nettype wire

/* hw/adc_device_end.sv */
/*
 * Converter control logic: clock divider, power-down / standby sequencing,
 * output coding, output three-state control and reference selection.
 * Assumes clk is the incoming sample clock and that the host end keeps
 * the straps steady and drives the command channel synchronously.
 */
`timescale 1ns/100ps
`default_nettype none

module adc_device_end
	import adc_ctrl_pkg::*;
(
	input  wire logic                clk,
	input  wire logic                rstn,
	input  wire logic                ce,
	adc_link_if.device               link,
	input  wire logic [SAMPLE_W-1:0] sample_in,
	input  wire logic                over_range_in,
	output pwr_state_t               power_state,
	output logic                     reference_on,
	output logic                     bias_on,
	output logic                     clock_on,
	output logic                     ref_internal,
	output logic                     ref_external
);

	// ********************************************************
	// Serial settings
	// ********************************************************
	div_sel_t   div_reg,    div_next;
	fmt_t       fmt_reg,    fmt_next;
	pwr_cmd_t   pwr_reg,    pwr_next;
	pin_fn_t    pin_fn_reg, pin_fn_next;

	always_comb
	begin
		div_next    = div_reg;
		fmt_next    = fmt_reg;
		pwr_next    = pwr_reg;
		pin_fn_next = pin_fn_reg;
		// Code 3 is reserved in every setting and leaves it unchanged
		if (link.cmd_valid && link.cmd_data != CMD_ILLEGAL)
		begin
			unique case (link.cmd_addr)
				CMD_DIV:    div_next    = div_sel_t'(link.cmd_data);
				CMD_POWER:  pwr_next    = pwr_cmd_t'(link.cmd_data);
				CMD_FORMAT: fmt_next    = fmt_t'(link.cmd_data);
				CMD_PIN_FN: pin_fn_next = pin_fn_t'(link.cmd_data);
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			div_reg    <= DIV_BY_1;
			fmt_reg    <= FMT_OFFSET;
			pwr_reg    <= PWR_RUN;
			pin_fn_reg <= PIN_NONE;
		end
		else if (ce)
		begin
			div_reg    <= div_next;
			fmt_reg    <= fmt_next;
			pwr_reg    <= pwr_next;
			pin_fn_reg <= pin_fn_next;
		end
	end

	// ********************************************************
	// Effective mode: serial settings or straps
	// ********************************************************
	logic     pd_req;
	logic     sb_req;
	logic     out_dis;
	fmt_t     fmt_eff;
	div_sel_t div_eff;

	always_comb
	begin
		if (link.serial_mode)
		begin
			pd_req  = (pwr_reg == PWR_DOWN) ||
				(pin_fn_reg == PIN_POWER_DOWN && link.mode_pin);
			sb_req  = (pwr_reg == PWR_STANDBY);
			out_dis = (pin_fn_reg == PIN_OUT_ENABLE) && link.mode_pin;
			fmt_eff = fmt_reg;
			div_eff = div_reg;
		end
		else
		begin
			pd_req  = link.power_down_strap;
			sb_req  = 1'b0;
			out_dis = link.data_or_powerdown_strap;
			fmt_eff = link.clock_or_format_strap ? FMT_TWOS : FMT_OFFSET;
			div_eff = DIV_BY_1;
		end
	end

	// ********************************************************
	// Power sequencing
	// ********************************************************
	pwr_state_t        state_reg, state_next;
	logic [WAKE_W-1:0] down_cnt_reg, down_cnt_next;
	logic [WAKE_W-1:0] wake_cnt_reg, wake_cnt_next;
	logic              ref_on_reg, ref_on_next;
	logic              clk_on_reg, clk_on_next;
	logic              ref_int_reg, ref_int_next;
	logic              ref_ext_reg, ref_ext_next;

	always_comb
	begin
		state_next    = state_reg;
		down_cnt_next = down_cnt_reg;
		wake_cnt_next = wake_cnt_reg;
		unique case (state_reg)
			ST_RUN:
			begin
				if (pd_req)
				begin
					state_next    = ST_DOWN;
					down_cnt_next = '0;
				end
				else if (sb_req)
					state_next = ST_STANDBY;
			end
			ST_STANDBY:
			begin
				if (pd_req)
				begin
					state_next    = ST_DOWN;
					down_cnt_next = '0;
				end
				else if (!sb_req)
				begin
					state_next    = ST_WAKE;
					wake_cnt_next = STANDBY_WAKE_CYC;
				end
			end
			ST_DOWN:
			begin
				// Charge lost grows with time down, so the wait grows too
				if (down_cnt_reg != PD_WAKE_MAX_CYC)
					down_cnt_next = down_cnt_reg + 1'b1;
				if (!pd_req)
				begin
					state_next    = ST_WAKE;
					wake_cnt_next = (down_cnt_reg == '0) ? WAKE_W'(1)
						: down_cnt_reg;
				end
			end
			ST_WAKE:
			begin
				if (pd_req)
				begin
					state_next    = ST_DOWN;
					down_cnt_next = '0;
				end
				else if (wake_cnt_reg <= WAKE_W'(1))
					state_next = ST_RUN;
				else
					wake_cnt_next = wake_cnt_reg - 1'b1;
			end
		endcase
		ref_on_next  = (state_next != ST_DOWN);
		clk_on_next  = (state_next == ST_RUN) || (state_next == ST_WAKE);
		ref_int_next = ref_on_next && (link.sense_level == SENSE_GND);
		ref_ext_next = (link.sense_level == SENSE_ANALOG_SUPPLY);
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_reg    <= ST_RUN;
			down_cnt_reg <= '0;
			wake_cnt_reg <= '0;
			ref_on_reg   <= 1'b1;
			clk_on_reg   <= 1'b1;
			ref_int_reg  <= 1'b0;
			ref_ext_reg  <= 1'b0;
		end
		else if (ce)
		begin
			state_reg    <= state_next;
			down_cnt_reg <= down_cnt_next;
			wake_cnt_reg <= wake_cnt_next;
			ref_on_reg   <= ref_on_next;
			clk_on_reg   <= clk_on_next;
			ref_int_reg  <= ref_int_next;
			ref_ext_reg  <= ref_ext_next;
		end
	end

	// ********************************************************
	// Divider, pipeline and output drivers
	// ********************************************************
	logic [1:0]        div_cnt_reg, div_cnt_next;
	logic [WORD_W-1:0] pipe_reg [PIPE_DEPTH];
	logic [WORD_W-1:0] pipe_next [PIPE_DEPTH];
	logic [WORD_W-1:0] word_reg, word_next;
	logic              dcc_reg, dcc_next;
	logic              oe_reg, oe_next;
	logic              sample_tick;
	logic [1:0]        div_top;
	logic [SAMPLE_W-1:0] coded;

	adc_out_coder u_coder (
		.fmt   (fmt_eff),
		.raw   (pipe_reg[PIPE_DEPTH-1][SAMPLE_W-1:0]),
		.coded (coded)
	);

	always_comb
	begin
		unique case (div_eff)
			DIV_BY_2: div_top = 2'h1;
			DIV_BY_4: div_top = 2'h3;
			default:  div_top = 2'h0;
		endcase
		// Only converts in full run; wake-up output is not trusted
		sample_tick  = (state_reg == ST_RUN) && (div_cnt_reg == 2'h0);
		if (state_reg != ST_RUN)
			div_cnt_next = 2'h0;
		else if (div_cnt_reg == 2'h0)
			div_cnt_next = div_top;
		else
			div_cnt_next = div_cnt_reg - 1'b1;
		pipe_next = pipe_reg;
		word_next = word_reg;
		if (sample_tick)
		begin
			pipe_next[0] = {over_range_in, sample_in};
			for (int i = 1; i < PIPE_DEPTH; i++)
				pipe_next[i] = pipe_reg[i-1];
			word_next = {pipe_reg[PIPE_DEPTH-1][WORD_W-1], coded};
		end
		dcc_next = sample_tick;
		oe_next  = (state_next == ST_RUN || state_next == ST_WAKE) &&
			!out_dis;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			div_cnt_reg <= 2'h0;
			for (int i = 0; i < PIPE_DEPTH; i++)
				pipe_reg[i] <= '0;
			word_reg <= '0;
			dcc_reg  <= 1'b0;
			oe_reg   <= 1'b0;
		end
		else if (ce)
		begin
			div_cnt_reg <= div_cnt_next;
			pipe_reg    <= pipe_next;
			word_reg    <= word_next;
			dcc_reg     <= dcc_next;
			oe_reg      <= oe_next;
		end
	end

	assign link.data_out           = word_reg;
	assign link.data_oe            = oe_reg;
	assign link.data_capture_clock = dcc_reg;
	assign link.dcc_oe             = oe_reg;
	assign power_state             = state_reg;
	assign reference_on            = ref_on_reg;
	assign bias_on                 = ref_on_reg;
	assign clock_on                = clk_on_reg;
	assign ref_internal            = ref_int_reg;
	assign ref_external            = ref_ext_reg;

endmodule // adc_device_end

`default_nettype wire

/* hw/adc_host_end.sv */
/*
 * Host logic: drives the straps, mode pin and command channel from
 * Wishbone-visible registers and captures each output word.
 * Assumes a classic Wishbone master on the same clock as the link.
 */
`timescale 1ns/100ps
`default_nettype none

module adc_host_end
	import adc_ctrl_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        ce,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	adc_link_if.host         link
);

	// ********************************************************
	// Bus slave and control registers
	// ********************************************************
	logic [CTRL_W-1:0] ctrl_reg, ctrl_next;
	logic [3:0]        cmd_reg, cmd_next;
	logic              cmd_valid_reg, cmd_valid_next;
	logic              ack_reg, ack_next;
	logic [31:0]       rdata_reg, rdata_next;
	logic [WORD_W-1:0] cap_word_reg, cap_word_next;
	logic [7:0]        cap_cnt_reg, cap_cnt_next;
	logic              cap_oe_reg, cap_oe_next;
	logic              req;
	logic              wr_fire;

	always_comb
	begin
		req            = wb_cyc_i && wb_stb_i && !ack_reg;
		// Writes commit on the edge where the master sees ack
		wr_fire        = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg &&
			wb_sel_i[0];
		ack_next       = req;
		rdata_next     = rdata_reg;
		ctrl_next      = ctrl_reg;
		cmd_next       = cmd_reg;
		cmd_valid_next = 1'b0;
		if (req)
		begin
			unique case (wb_adr_i)
				ADR_CTRL:   rdata_next = {25'h0, ctrl_reg};
				ADR_CMD:    rdata_next = {26'h0, cmd_reg[3:2], 2'h0,
					cmd_reg[1:0]};
				ADR_SAMPLE: rdata_next = {cap_cnt_reg, 7'h0, cap_oe_reg,
					3'h0, cap_word_reg};
				default:    rdata_next = 32'h0;
			endcase
		end
		if (wr_fire && wb_adr_i == ADR_CTRL)
			ctrl_next = wb_dat_i[CTRL_W-1:0];
		if (wr_fire && wb_adr_i == ADR_CMD)
		begin
			cmd_next       = {wb_dat_i[CMD_DAT_LSB+:2], wb_dat_i[CMD_ADR_LSB+:2]};
			cmd_valid_next = 1'b1;
		end
		cap_oe_next   = link.data_oe;
		cap_word_next = cap_word_reg;
		cap_cnt_next  = cap_cnt_reg;
		if (link.data_capture_clock && link.dcc_oe && link.data_oe)
		begin
			cap_word_next = link.data_out;
			cap_cnt_next  = cap_cnt_reg + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ctrl_reg      <= CTRL_RESET;
			cmd_reg       <= 4'h0;
			cmd_valid_reg <= 1'b0;
			ack_reg       <= 1'b0;
			rdata_reg     <= 32'h0;
			cap_word_reg  <= '0;
			cap_cnt_reg   <= 8'h00;
			cap_oe_reg    <= 1'b0;
		end
		else if (ce)
		begin
			ctrl_reg      <= ctrl_next;
			cmd_reg       <= cmd_next;
			cmd_valid_reg <= cmd_valid_next;
			ack_reg       <= ack_next;
			rdata_reg     <= rdata_next;
			cap_word_reg  <= cap_word_next;
			cap_cnt_reg   <= cap_cnt_next;
			cap_oe_reg    <= cap_oe_next;
		end
	end

	assign wb_ack_o                     = ack_reg;
	assign wb_dat_o                     = rdata_reg;
	assign link.serial_mode             = ctrl_reg[CTRL_SERIAL];
	assign link.power_down_strap        = ctrl_reg[CTRL_POWER_DOWN_STRAP];
	assign link.clock_or_format_strap   = ctrl_reg[CTRL_FMT];
	assign link.data_or_powerdown_strap = ctrl_reg[CTRL_DPD];
	assign link.mode_pin                = ctrl_reg[CTRL_MODE];
	assign link.sense_level             = ctrl_reg[CTRL_SENSE+:2];
	assign link.cmd_valid               = cmd_valid_reg;
	assign link.cmd_addr                = cmd_reg[1:0];
	assign link.cmd_data                = cmd_reg[3:2];

endmodule // adc_host_end

`default_nettype wire

/* hw/adc_link_if.sv */
/*
 * Link between the host logic and the converter control logic: straps,
 * mode pin, command channel and the three-state output word.
 * Assumes both ends run on the same clock; the bench joins them.
 */
`timescale 1ns/100ps
`default_nettype none

interface adc_link_if
	import adc_ctrl_pkg::*;
();
	logic                serial_mode;
	logic                power_down_strap;
	logic                clock_or_format_strap;
	logic                data_or_powerdown_strap;
	logic                mode_pin;
	logic [1:0]          sense_level;
	logic                cmd_valid;
	logic [1:0]          cmd_addr;
	logic [1:0]          cmd_data;
	logic [WORD_W-1:0]   data_out;
	logic                data_oe;
	logic                data_capture_clock;
	logic                dcc_oe;

	modport device (
		input  serial_mode, power_down_strap, clock_or_format_strap,
		input  data_or_powerdown_strap, mode_pin, sense_level,
		input  cmd_valid, cmd_addr, cmd_data,
		output data_out, data_oe, data_capture_clock, dcc_oe
	);

	modport host (
		output serial_mode, power_down_strap, clock_or_format_strap,
		output data_or_powerdown_strap, mode_pin, sense_level,
		output cmd_valid, cmd_addr, cmd_data,
		input  data_out, data_oe, data_capture_clock, dcc_oe
	);
endinterface

`default_nettype wire

/* hw/adc_out_coder.sv */
/*
 * Output coding of one conversion result: offset binary, twos
 * complement or gray code. Purely combinational.
 * Assumes the raw result arrives in offset binary.
 */
`timescale 1ns/100ps
`default_nettype none

module adc_out_coder
	import adc_ctrl_pkg::*;
(
	input  wire fmt_t                fmt,
	input  wire logic [SAMPLE_W-1:0] raw,
	output logic [SAMPLE_W-1:0]      coded
);
	always_comb
	begin
		unique case (fmt)
			FMT_TWOS: coded = {~raw[SAMPLE_W-1], raw[SAMPLE_W-2:0]};
			FMT_GRAY: coded = raw ^ (raw >> 1);
			default:  coded = raw;
		endcase
	end
endmodule // adc_out_coder

`default_nettype wire

/* verification/adc_link_chk.sv */
/*
 * Checker for the converter link: relations between the straps, the
 * command channel and the output enables of the device end.
 * Assumes one clock and an asynchronous active-low reset.
 */
`timescale 1ns/100ps
`default_nettype none

module adc_link_chk
	import adc_ctrl_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic       serial_mode,
	input  wire logic       power_down_strap,
	input  wire logic       data_or_powerdown_strap,
	input  wire logic       mode_pin,
	input  wire logic       cmd_valid,
	input  wire logic [1:0] cmd_addr,
	input  wire logic [1:0] cmd_data,
	input  wire logic       data_oe,
	input  wire logic       data_capture_clock,
	input  wire logic       dcc_oe
);
	// ********************************************************
	// Shadow of the serial settings: pin function and divider
	// ********************************************************
	logic [3:0] set_reg;
	logic [3:0] set_next;

	always_comb
	begin
		set_next = set_reg;
		if (cmd_valid && cmd_data != 2'h3 && cmd_addr == CMD_DIV)
			set_next[1:0] = cmd_data;
		if (cmd_valid && cmd_data != 2'h3 && cmd_addr == CMD_PIN_FN)
			set_next[3:2] = cmd_data;
	end

	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
			set_reg <= 4'h0;
		else
			set_reg <= set_next;

	// ********************************************************
	// Properties
	// ********************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	property p_oe_pair;
		dcc_oe == data_oe;
	endproperty
	a_oe_pair: assert property (p_oe_pair)
		else $error("capture clock enable differs from data enable");

	property p_strap_pd;
		$rose(power_down_strap) && !serial_mode |-> ##[1:3] !data_oe;
	endproperty
	a_strap_pd: assert property (p_strap_pd)
		else $error("outputs still driven after strap power-down");

	property p_strap_dis;
		(!serial_mode && data_or_powerdown_strap) [*2] |-> !data_oe;
	endproperty
	a_strap_dis: assert property (p_strap_dis)
		else $error("outputs driven while strap disables them");

	property p_pin_oeb;
		(serial_mode && set_reg[3:2] == PIN_OUT_ENABLE && mode_pin) [*2]
			|-> !data_oe;
	endproperty
	a_pin_oeb: assert property (p_pin_oeb)
		else $error("outputs driven while enable pin is high");

	property p_cmd_down;
		serial_mode && cmd_valid && cmd_addr == CMD_POWER
			&& cmd_data == PWR_DOWN |-> ##[1:3] !data_oe;
	endproperty
	a_cmd_down: assert property (p_cmd_down)
		else $error("outputs driven after power-down command");

	property p_cmd_stby;
		serial_mode && cmd_valid && cmd_addr == CMD_POWER
			&& cmd_data == PWR_STANDBY |-> ##[1:3] !data_oe;
	endproperty
	a_cmd_stby: assert property (p_cmd_stby)
		else $error("outputs driven after standby command");

	property p_div2;
		serial_mode && set_reg[1:0] == DIV_BY_2
			&& $past(set_reg[1:0]) == DIV_BY_2 && data_capture_clock
			|=> !data_capture_clock;
	endproperty
	a_div2: assert property (p_div2)
		else $error("word rate too high for divide by two");

	property p_div4;
		serial_mode && set_reg[1:0] == DIV_BY_4
			&& $past(set_reg[1:0]) == DIV_BY_4 && data_capture_clock
			|=> !data_capture_clock [*3];
	endproperty
	a_div4: assert property (p_div4)
		else $error("word rate too high for divide by four");

endmodule // adc_link_chk

`default_nettype wire

/* verification/tb_adc_mode_pin_power_format_control.sv */
/*
 * Testbench: host end and device end joined by the link, driven over
 * classic Wishbone, with the link checker beside them.
 * Assumes the package, the link and both ends are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none

module tb_adc_mode_pin_power_format_control
	import adc_ctrl_pkg::*;
;
	logic        clk;
	logic        rstn;
	logic        wb_cyc;
	logic        wb_stb;
	logic        wb_we;
	logic [3:0]  wb_adr;
	logic [31:0] wb_wdat;
	logic [31:0] wb_rdat;
	logic [31:0] rd;
	logic        wb_ack;
	logic [11:0] smp;
	logic        ovr;
	pwr_state_t  pst;
	logic        ref_on;
	logic        bias_on;
	logic        clk_on;
	logic        ref_int;
	logic        ref_ext;
	int          mismatches;
	int          check_count;
	int          n;

	adc_link_if link ();

	always #12.5 clk = ~clk;

	adc_device_end u_adc_device_end (.clk(clk), .rstn(rstn), .ce(1'b1),
		.link(link), .sample_in(smp), .over_range_in(ovr),
		.power_state(pst), .reference_on(ref_on), .bias_on(bias_on),
		.clock_on(clk_on), .ref_internal(ref_int), .ref_external(ref_ext));

	adc_host_end u_adc_host_end (.clk(clk), .rstn(rstn), .ce(1'b1),
		.wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
		.wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_wdat),
		.wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .link(link));

	adc_link_chk u_adc_link_chk (.clk(clk), .rstn(rstn),
		.serial_mode(link.serial_mode), .mode_pin(link.mode_pin),
		.power_down_strap(link.power_down_strap),
		.data_or_powerdown_strap(link.data_or_powerdown_strap),
		.cmd_valid(link.cmd_valid), .cmd_addr(link.cmd_addr),
		.cmd_data(link.cmd_data), .data_oe(link.data_oe),
		.data_capture_clock(link.data_capture_clock),
		.dcc_oe(link.dcc_oe));

	// ********************************************************
	// Compare, bus and expectation helpers
	// ********************************************************
	task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic check_in(input int got, input int lo, input int hi);
		check_count++;
		if (got < lo || got > hi)
		begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
		end
	endtask

	task automatic results;
		$display("checks=%0d mismatches=%0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// No fixed answer time assumed; the count only guards against a hang
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= w;
		wb_adr <= a;
		wb_wdat <= d;
		do
		begin
			@(posedge clk);
			k++;
		end
		while (wb_ack !== 1'b1 && k < 50);
		rd = wb_rdat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		if (k >= 50)
			mismatches++;
	endtask

	task automatic cmd(input logic [1:0] a, input logic [1:0] d);
		bus(1'b1, ADR_CMD, {26'h0, d, 2'h0, a});
	endtask

	task automatic ctrl(input logic [6:0] v);
		bus(1'b1, ADR_CTRL, {25'h0, v});
	endtask

	task automatic wait_st(input pwr_state_t s);
		n = 0;
		while (pst !== s && n < 2000)
		begin
			@(posedge clk);
			n++;
		end
		check_in(n, 0, 1999);
	endtask

	function automatic logic [12:0] word(input fmt_t f, input logic o,
		input logic [11:0] s);
		case (f)
			FMT_TWOS: return {o, s ^ 12'h800};
			FMT_GRAY: return {o, s ^ (s >> 1)};
			default:  return {o, s};
		endcase
	endfunction

	// Old word must still stand on the tenth tick, new one on the eleventh
	task automatic fmt_run(input fmt_t f, input logic [11:0] s1);
		logic [12:0] e0;
		@(posedge clk);
		smp <= 12'($urandom);
		ovr <= 1'b0;
		repeat (12) @(posedge clk);
		e0 = word(f, 1'b0, smp);
		smp <= s1;
		ovr <= 1'b1;
		repeat (10) @(posedge clk);
		check_eq(32'(link.data_out), 32'(e0));
		@(posedge clk);
		check_eq(32'(link.data_out), 32'(word(f, 1'b1, s1)));
		bus(1'b0, ADR_SAMPLE, 32'h0);
		check_eq(32'(rd[12:0]), 32'(word(f, 1'b1, s1)));
	endtask

	// ********************************************************
	// Main sequence
	// ********************************************************
	initial
	begin
		clk = 1'b0;
		rstn = 1'b0;
		wb_cyc = 1'b0;
		wb_stb = 1'b0;
		wb_we = 1'b0;
		wb_adr = 4'h0;
		wb_wdat = 32'h0;
		smp = 12'h000;
		ovr = 1'b0;
		mismatches = 0;
		check_count = 0;
		void'($urandom(32'hBB31DB32));
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		bus(1'b0, ADR_CTRL, 32'h0);
		check_eq(rd, 32'h0);
		check_eq(32'(pst), 32'(ST_RUN));
		for (int i = 0; i < 2; i++)
		begin
			ctrl(i ? 7'h04 : 7'h00);
			fmt_run(i ? FMT_TWOS : FMT_OFFSET, i ? 12'hFFF : 12'h000);
		end
		// Strap asks for twos complement; the commands must win
		ctrl(7'h05);
		cmd(CMD_DIV, DIV_BY_1);
		for (int i = 0; i < 3; i++)
		begin
			cmd(CMD_FORMAT, 2'(i));
			fmt_run(fmt_t'(i), 12'($urandom));
		end
		for (int i = 0; i < 3; i++)
		begin
			cmd(CMD_DIV, 2'(i));
			repeat (8) @(posedge clk);
			n = 0;
			repeat (64)
			begin
				@(posedge clk);
				if (link.data_capture_clock === 1'b1)
					n++;
			end
			check_in(n, (64 >> i) - 1, (64 >> i) + 1);
		end
		cmd(CMD_DIV, DIV_BY_1);
		cmd(CMD_POWER, PWR_STANDBY);
		wait_st(ST_STANDBY);
		check_eq({ref_on, bias_on, clk_on, link.data_oe}, 4'hC);
		cmd(CMD_POWER, PWR_RUN);
		wait_st(ST_WAKE);
		wait_st(ST_RUN);
		check_in(n, 39, 41);
		// Power-down by command, not pin, so that path is exercised too
		cmd(CMD_POWER, PWR_DOWN);
		wait_st(ST_DOWN);
		check_eq(link.data_oe, 1'b0);
		cmd(CMD_POWER, PWR_RUN);
		wait_st(ST_RUN);
		check_eq(link.data_oe, 1'b1);
		cmd(CMD_PIN_FN, PIN_POWER_DOWN);
		ctrl(7'h11);
		wait_st(ST_DOWN);
		check_eq({ref_on, bias_on, clk_on, link.data_oe}, 4'h0);
		ctrl(7'h01);
		wait_st(ST_RUN);
		cmd(CMD_PIN_FN, PIN_OUT_ENABLE);
		ctrl(7'h11);
		repeat (3) @(posedge clk);
		check_eq(link.data_oe, 1'b0);
		ctrl(7'h01);
		repeat (3) @(posedge clk);
		check_eq(link.data_oe, 1'b1);
		for (int i = 0; i < 2; i++)
		begin
			ctrl(i ? 7'h60 : 7'h00);
			repeat (3) @(posedge clk);
			check_eq({ref_int, ref_ext}, i ? 2'b01 : 2'b10);
		end
		ctrl(7'h08);
		repeat (3) @(posedge clk);
		check_eq(link.data_oe, 1'b0);
		// Short and long stay in power-down: wake must scale, then cap
		for (int i = 0; i < 2; i++)
		begin
			ctrl(7'h02);
			wait_st(ST_DOWN);
			repeat (i ? 600 : 20) @(posedge clk);
			ctrl(7'h00);
			wait_st(ST_WAKE);
			wait_st(ST_RUN);
			check_in(n, i ? 399 : 20, i ? 401 : 30);
		end
		bus(1'b1, 4'hC, 32'hFFFFFFFF);
		bus(1'b0, 4'hC, 32'h0);
		check_eq(rd, 32'h0);
		results();
	end

	// Whole run is under two thousand cycles; this is ample margin
	initial
	begin
		repeat (20000) @(posedge clk);
		mismatches++;
		results();
	end

endmodule // tb_adc_mode_pin_power_format_control

`default_nettype wire
